// File: rtl/lstr_trigger.v
// Line state trigger response with APB register access
`timescale 1ns/1ps
// Overview of operation
// - Trigger definition bits 3-7 enable super idle, master, halt, quiet, noise.
// - Any enabled met condition sets trigger occurred flag automatically.
// - On trigger, bits 0-2 load current transmit state.
// - With mask set, flag rising sets connection service event bit.
// - Transmit mode 110 means quiet transmit.
// - On trigger, trigger transition configuration loads configuration register.
// - Configuration reload always accompanies transmit reload; no separate enable.
// - Software configuration writes ignored while trigger reload is in progress.
// - Scrub enabled: two invalid symbols, then idles for scrub time, then switch.
// - Noise counter decrements on noise/unknown/active, reloads otherwise; expiry triggers.
// - Super idle after idle persists eight pairs plus one pair.
module lstr_trigger (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Receive line state
   input wire pair_valid,
   input wire [2:0] rx_line_state,
   input wire signal_detect,
   // Transmit and switch
   output wire [2:0] current_transmit_state,
   output wire [7:0] configuration,
   output wire [1:0] scrub_symbol,
   output wire scrub_active
);
`include "lstr_map.vh"

   localparam ST_IDLE = 2'b00;
   localparam ST_INVAL = 2'b01;
   localparam ST_SCRUB = 2'b10;
   localparam ST_LOAD = 2'b11;

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   reg [7:0] trigger_definition_q;
   reg [7:0] ttc_q;
   reg [7:0] config_q;
   reg tco_q;
   reg trigger_occurred_mask_q;
   reg cse_q;
   reg [2:0] cur_tx_q;
   reg scrub_en_q;
   reg [15:0] noise_thr_q;
   reg [15:0] noise_cnt_q;
   reg [15:0] scrub_thr_q;
   reg [15:0] scrub_cnt_q;
   reg [1:0] inv_cnt_q;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [31:0] prdata_q;
   reg [31:0] rd_d;
   reg slverr_q;

   wire super_idle_line_state;
   wire noise_expired;
   wire wr_acc;
   wire rd_acc;
   wire trig_fire;
   wire reload_busy;
   reg addr_hit;

   function [31:0] lstr_pad8;
      input [7:0] v;
      begin
         lstr_pad8 = {24'h000000, v};
      end
   endfunction

   function wr_at;
      input [7:0] a;
      begin
         wr_at = wr_acc && (paddr == a);
      end
   endfunction

   lstr_idle_timer u_idle (
      .pclk(pclk),
      .presetn(presetn),
      .pair_valid(pair_valid),
      .rx_line_state(rx_line_state),
      .super_idle_line_state(super_idle_line_state)
   );

   // -------------------------------------------------------------
   // APB slave: zero wait states
   // -------------------------------------------------------------
   assign pready = 1'b1;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && !penable && !pwrite;

   always @* begin
      addr_hit = 1'b1;
      rd_d = 32'h00000000;
      case (paddr)
         `LSTR_OFF_TRIG_DEF: rd_d = lstr_pad8(trigger_definition_q);
         `LSTR_OFF_TTC: rd_d = lstr_pad8(ttc_q);
         `LSTR_OFF_CONFIG: rd_d = lstr_pad8(config_q);
         `LSTR_OFF_CONN_COND: rd_d = {31'h00000000, tco_q};
         `LSTR_OFF_CONN_MASK: rd_d = {31'h00000000, trigger_occurred_mask_q};
         `LSTR_OFF_RCV_COND_B: rd_d = {31'h00000000, cse_q};
         `LSTR_OFF_CUR_TX: rd_d = {29'h00000000, cur_tx_q};
         `LSTR_OFF_MODE_TWO: rd_d = {31'h00000000, scrub_en_q};
         `LSTR_OFF_NOISE_THR: rd_d = {16'h0000, noise_thr_q};
         `LSTR_OFF_SCRUB_THR: rd_d = {16'h0000, scrub_thr_q};
         default: addr_hit = 1'b0;
      endcase
   end

   // Read data captured in setup so it is stable through the access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
         slverr_q <= 1'b0;
      end else if (psel && !penable) begin
         slverr_q <= !addr_hit;
         if (rd_acc) begin
            prdata_q <= rd_d;
         end
      end
   end

   assign prdata = prdata_q;
   assign pslverr = psel && penable && slverr_q;

   // -------------------------------------------------------------
   // Noise counter
   // -------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         noise_cnt_q <= `LSTR_NOISE_RST;
      end else if (!signal_detect) begin
         noise_cnt_q <= noise_thr_q;
      end else if (rx_line_state == `LSTR_LS_NOISE ||
                   rx_line_state == `LSTR_LS_UNKNOWN ||
                   rx_line_state == `LSTR_LS_ACTIVE) begin
         if (pair_valid && noise_cnt_q != 16'h0000) begin
            noise_cnt_q <= noise_cnt_q - 16'h0001;
         end
      end else begin
         noise_cnt_q <= noise_thr_q;
      end
   end

   assign noise_expired = (noise_cnt_q == 16'h0000);

   // -------------------------------------------------------------
   // Trigger detection
   // -------------------------------------------------------------
   assign trig_fire = state_q == ST_IDLE && (
      (trigger_definition_q[`LSTR_TD_SUPER_IDLE_LINE_STATE] && super_idle_line_state) ||
      (trigger_definition_q[`LSTR_TD_MLS] &&
         rx_line_state == `LSTR_LS_MASTER) ||
      (trigger_definition_q[`LSTR_TD_HLS] &&
         rx_line_state == `LSTR_LS_HALT) ||
      (trigger_definition_q[`LSTR_TD_QLS] &&
         rx_line_state == `LSTR_LS_QUIET) ||
      (trigger_definition_q[`LSTR_TD_NT] && noise_expired));

   // Level conditions would retrigger every cycle; one response per
   // event is held off until the flag is cleared by software.
   wire trig_event;
   assign trig_event = trig_fire && !tco_q;

   // -------------------------------------------------------------
   // Response sequencer: optional scrub then configuration load
   // -------------------------------------------------------------
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (trig_event) begin
               state_d = scrub_en_q ? ST_INVAL : ST_LOAD;
            end
         end
         ST_INVAL: begin
            if (inv_cnt_q == `LSTR_SCRUB_INV_CNT - 2'h1) begin
               state_d = ST_SCRUB;
            end
         end
         ST_SCRUB: begin
            if (scrub_cnt_q == 16'h0000) begin
               state_d = ST_LOAD;
            end
         end
         ST_LOAD: state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   assign reload_busy = (state_q != ST_IDLE) || trig_event;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         inv_cnt_q <= 2'h0;
         scrub_cnt_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         if (state_q == ST_INVAL) begin
            inv_cnt_q <= inv_cnt_q + 2'h1;
         end else begin
            inv_cnt_q <= 2'h0;
         end
         if (state_q == ST_INVAL) begin
            scrub_cnt_q <= scrub_thr_q;
         end else if (state_q == ST_SCRUB && scrub_cnt_q != 16'h0000) begin
            scrub_cnt_q <= scrub_cnt_q - 16'h0001;
         end
      end
   end

   assign scrub_active = (state_q == ST_INVAL) || (state_q == ST_SCRUB);
   assign scrub_symbol = (state_q == ST_INVAL) ? `LSTR_SYM_INVALID :
                         (state_q == ST_SCRUB) ? `LSTR_SYM_IDLE :
                         `LSTR_SYM_PASS;

   // -------------------------------------------------------------
   // Software registers and trigger effects
   // -------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trigger_definition_q <= 8'h00;
         ttc_q <= 8'h00;
         config_q <= 8'h00;
         tco_q <= 1'b0;
         trigger_occurred_mask_q <= 1'b0;
         cse_q <= 1'b0;
         cur_tx_q <= 3'h0;
         scrub_en_q <= 1'b0;
         noise_thr_q <= `LSTR_NOISE_RST;
         scrub_thr_q <= `LSTR_SCRUB_RST;
      end else begin
         if (wr_at(`LSTR_OFF_TRIG_DEF)) begin
            trigger_definition_q <= pwdata[7:0];
         end
         if (wr_at(`LSTR_OFF_TTC)) begin
            ttc_q <= pwdata[7:0];
         end
         if (wr_at(`LSTR_OFF_CONN_MASK)) begin
            trigger_occurred_mask_q <= pwdata[`LSTR_CM_TRIGGER_OCCURRED_MASK];
         end
         if (wr_at(`LSTR_OFF_MODE_TWO)) begin
            scrub_en_q <= pwdata[`LSTR_M2_SCRUB];
         end
         if (wr_at(`LSTR_OFF_NOISE_THR)) begin
            noise_thr_q <= pwdata[15:0];
         end
         if (wr_at(`LSTR_OFF_SCRUB_THR)) begin
            scrub_thr_q <= pwdata[15:0];
         end
         // Write one to clear; a trigger in the same cycle wins
         if (trig_event) begin
            tco_q <= 1'b1;
         end else if (wr_at(`LSTR_OFF_CONN_COND) &&
                      pwdata[`LSTR_CC_TCO]) begin
            tco_q <= 1'b0;
         end
         if (trig_event && trigger_occurred_mask_q) begin
            cse_q <= 1'b1;
         end else if (wr_at(`LSTR_OFF_RCV_COND_B) &&
                      pwdata[`LSTR_RB_CSE]) begin
            cse_q <= 1'b0;
         end
         // Quiet code passes straight through like every other mode
         if (trig_event) begin
            cur_tx_q <= trigger_definition_q[`LSTR_TD_MODE_MSB:
                                             `LSTR_TD_MODE_LSB];
         end else if (wr_at(`LSTR_OFF_CUR_TX)) begin
            cur_tx_q <= pwdata[2:0];
         end
         if (state_q == ST_LOAD) begin
            config_q <= ttc_q;
         end else if (wr_at(`LSTR_OFF_CONFIG) && !reload_busy) begin
            config_q <= pwdata[7:0];
         end
      end
   end

   assign current_transmit_state = cur_tx_q;
   assign configuration = config_q;

endmodule

// File: rtl/lstr_map.vh
// Register map, field positions and codes of the trigger response block
`ifndef LSTR_MAP_VH
`define LSTR_MAP_VH

`define LSTR_ADDR_W 8
// Byte addresses of the registers
`define LSTR_OFF_TRIG_DEF 8'h00
`define LSTR_OFF_TTC 8'h04
`define LSTR_OFF_CONFIG 8'h08
`define LSTR_OFF_CONN_COND 8'h0C
`define LSTR_OFF_CONN_MASK 8'h10
`define LSTR_OFF_RCV_COND_B 8'h14
`define LSTR_OFF_CUR_TX 8'h18
`define LSTR_OFF_MODE_TWO 8'h1C
`define LSTR_OFF_NOISE_THR 8'h20
`define LSTR_OFF_SCRUB_THR 8'h24

// Trigger definition fields
`define LSTR_TD_MODE_LSB 0
`define LSTR_TD_MODE_MSB 2
`define LSTR_TD_SUPER_IDLE_LINE_STATE 3
`define LSTR_TD_MLS 4
`define LSTR_TD_HLS 5
`define LSTR_TD_QLS 6
`define LSTR_TD_NT 7
// Other single-bit fields
`define LSTR_CC_TCO 0
`define LSTR_CM_TRIGGER_OCCURRED_MASK 0
`define LSTR_RB_CSE 0
`define LSTR_M2_SCRUB 0

// Transmit modes
`define LSTR_TX_QUIET 3'h6

// Received line state codes
`define LSTR_LS_ACTIVE 3'h0
`define LSTR_LS_IDLE 3'h1
`define LSTR_LS_HALT 3'h2
`define LSTR_LS_MASTER 3'h3
`define LSTR_LS_QUIET 3'h4
`define LSTR_LS_NOISE 3'h5
`define LSTR_LS_UNKNOWN 3'h6

// Idle persistence: eight pairs plus one
`define LSTR_IDLE_PAIRS 4'h9
`define LSTR_NOISE_RST 16'hFFFF
`define LSTR_SCRUB_RST 16'h0010

// Scrub output symbols
`define LSTR_SYM_INVALID 2'h1
`define LSTR_SYM_IDLE 2'h2
`define LSTR_SYM_PASS 2'h0
`define LSTR_SCRUB_INV_CNT 2'h2

`endif

// File: rtl/lstr_idle_timer.v
// Idle persistence timer that raises super idle line state
`timescale 1ns/1ps
module lstr_idle_timer (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Receive side
   input wire pair_valid,
   input wire [2:0] rx_line_state,
   // Result
   output wire super_idle_line_state
);
`include "lstr_map.vh"

   reg [3:0] idle_cnt_q;
   reg [3:0] idle_cnt_d;

   always @* begin
      idle_cnt_d = idle_cnt_q;
      if (rx_line_state != `LSTR_LS_IDLE) begin
         idle_cnt_d = 4'h0;
      end else if (pair_valid && idle_cnt_q != `LSTR_IDLE_PAIRS) begin
         idle_cnt_d = idle_cnt_q + 4'h1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt_q <= 4'h0;
      end else begin
         idle_cnt_q <= idle_cnt_d;
      end
   end

   assign super_idle_line_state = (idle_cnt_q == `LSTR_IDLE_PAIRS);

endmodule

// File: verif/lstr_trigger_assertions.sv
// Port-level checker for the line state trigger response block
`timescale 1ns/1ps
`include "lstr_map.vh"
module lstr_trigger_chk (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Receive line state
   input wire logic pair_valid,
   input wire logic [2:0] rx_line_state,
   input wire logic signal_detect,
   // Transmit and switch
   input wire logic [2:0] current_transmit_state,
   input wire logic [7:0] configuration,
   input wire logic [1:0] scrub_symbol,
   input wire logic scrub_active
);
   // -----------------------------------------
   // Shadow of the trigger setup
   // -----------------------------------------
   logic [7:0] td_q;
   logic [7:0] ttc_q;
   wire wr_w = psel && penable && pwrite;
   wire wr_tx = wr_w && paddr == `LSTR_OFF_CUR_TX;
   wire wr_cfg = wr_w && paddr == `LSTR_OFF_CONFIG;
   wire unm = psel && penable && paddr > `LSTR_OFF_SCRUB_THR;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         td_q <= 8'h00;
         ttc_q <= 8'h00;
      end else if (wr_w) begin
         if (paddr == `LSTR_OFF_TRIG_DEF) td_q <= pwdata[7:0];
         if (paddr == `LSTR_OFF_TTC) ttc_q <= pwdata[7:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_high: assert property (pready)
      else $error("pready low");
   a_unmapped_err: assert property (unm |-> pslverr)
      else $error("no error on unmapped access");
   a_unmapped_rd: assert property (unm && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_tx_load: assert property ($changed(current_transmit_state)
      && !$past(wr_tx) |-> current_transmit_state == $past(td_q[2:0]))
      else $error("transmit state not from trigger definition");
   a_no_trig: assert property (td_q[7:3] == 5'h00 && !wr_tx
      |=> $stable(current_transmit_state))
      else $error("transmit state moved with no trigger enabled");
   a_cfg_load: assert property ($changed(configuration)
      && !$past(wr_cfg) |-> configuration == $past(ttc_q))
      else $error("configuration not from transition value");
   a_scrub_seq: assert property ($rose(scrub_active) |->
      (scrub_symbol == `LSTR_SYM_INVALID) [*2]
      ##1 scrub_symbol == `LSTR_SYM_IDLE)
      else $error("scrub does not open with two invalid symbols");
   a_scrub_pass: assert property (!scrub_active |->
      scrub_symbol == `LSTR_SYM_PASS)
      else $error("scrub symbol outside scrub");
endmodule

bind lstr_trigger lstr_trigger_chk u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pair_valid(pair_valid),
   .rx_line_state(rx_line_state), .signal_detect(signal_detect),
   .current_transmit_state(current_transmit_state),
   .configuration(configuration), .scrub_symbol(scrub_symbol),
   .scrub_active(scrub_active));

// File: verif/tb_top.sv
// Self-checking bench for the line state trigger response block
`timescale 1ns/1ps
`include "lstr_map.vh"
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pair_valid, signal_detect;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [2:0] rx_line_state;
   wire [31:0] prdata;
   wire pready, pslverr, scrub_active;
   wire [2:0] current_transmit_state;
   wire [7:0] configuration;
   wire [1:0] scrub_symbol;
   logic [31:0] exp_q[$];
   int fails, n_tests;
   logic [7:0] ttc, td;
   logic [2:0] cond_ls[5] = '{`LSTR_LS_IDLE, `LSTR_LS_MASTER,
      `LSTR_LS_HALT, `LSTR_LS_QUIET, `LSTR_LS_NOISE};

   lstr_trigger uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pair_valid(pair_valid), .rx_line_state(rx_line_state),
      .signal_detect(signal_detect),
      .current_transmit_state(current_transmit_state),
      .configuration(configuration), .scrub_symbol(scrub_symbol),
      .scrub_active(scrub_active));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // -----------------------------------------
   // Bus tasks; reads note their expectation
   // -----------------------------------------
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task drv(input logic [2:0] ls, input int n);
      rx_line_state <= ls;
      repeat (n) @(posedge pclk);
   endtask
   // Bounded: a stuck sequencer must not hang the run. Sampled on the
   // falling edge, clear of the edge that launches the state change.
   task wait_scrub(input logic v);
      int n;
      n = 0;
      @(negedge pclk);
      while (n < 100 && scrub_active !== v) begin
         @(negedge pclk);
         n++;
      end
      n_tests++;
      if (scrub_active !== v) begin
         fails++;
         $display("Error t=%0t got %h exp %h", $time, scrub_active, v);
      end
      @(posedge pclk);
   endtask
   task stop_test;
      if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         n_tests++;
         if (prdata !== exp_q[0]) begin
            fails++;
            $display("Error t=%0t got %h exp %h", $time, prdata, exp_q[0]);
         end
         void'(exp_q.pop_front());
      end
   end

   initial begin
      #(25 * 20000);
      fails++;
      stop_test();
   end

   // -----------------------------------------
   // Main sequence
   // -----------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      {pair_valid, signal_detect} = 2'b11;
      rx_line_state = `LSTR_LS_IDLE;
      void'($urandom(2242));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`LSTR_OFF_TRIG_DEF, 32'h0);
      rd(`LSTR_OFF_NOISE_THR, 32'h0000FFFF);
      rd(`LSTR_OFF_SCRUB_THR, 32'h00000010);
      rd(8'h40, 32'h0);
      // Short noise threshold keeps the expiry case quick
      wr(`LSTR_OFF_NOISE_THR, 32'h3);
      for (int i = 0; i < 5; i++) begin
         ttc = (i == 3) ? ttc : 8'($urandom);
         td = (i == 2) ? 8'hE6 : (8'h08 << i) | 8'($urandom % 8);
         drv(i == 0 ? `LSTR_LS_HALT : `LSTR_LS_IDLE, 2);
         wr(`LSTR_OFF_TTC, {24'h0, ttc});
         wr(`LSTR_OFF_CONN_MASK, i % 2);
         wr(`LSTR_OFF_TRIG_DEF, {24'h0, td});
         drv(cond_ls[i], 12);
         drv(`LSTR_LS_IDLE, 2);
         rd(`LSTR_OFF_CONN_COND, 32'h1);
         rd(`LSTR_OFF_CUR_TX, {29'h0, td[2:0]});
         rd(`LSTR_OFF_CONFIG, {24'h0, ttc});
         rd(`LSTR_OFF_RCV_COND_B, i % 2);
         wr(`LSTR_OFF_TRIG_DEF, 32'h0);
         wr(`LSTR_OFF_CONN_COND, 32'h1);
         wr(`LSTR_OFF_RCV_COND_B, 32'h1);
         rd(`LSTR_OFF_CONN_COND, 32'h0);
      end
      // Loss of signal mid-noise must reload the counter: no expiry
      wr(`LSTR_OFF_TRIG_DEF, 32'h80);
      drv(`LSTR_LS_NOISE, 2);
      signal_detect <= 1'b0;
      drv(`LSTR_LS_NOISE, 1);
      signal_detect <= 1'b1;
      drv(`LSTR_LS_NOISE, 2);
      drv(`LSTR_LS_IDLE, 1);
      rd(`LSTR_OFF_CONN_COND, 32'h0);
      wr(`LSTR_OFF_MODE_TWO, 32'h1);
      wr(`LSTR_OFF_TTC, 32'hA5);
      wr(`LSTR_OFF_TRIG_DEF, 32'h21);
      drv(`LSTR_LS_HALT, 0);
      wait_scrub(1'b1);
      wr(`LSTR_OFF_CONFIG, 32'h5A);
      wait_scrub(1'b0);
      drv(`LSTR_LS_IDLE, 2);
      rd(`LSTR_OFF_CONFIG, 32'hA5);
      wr(`LSTR_OFF_TRIG_DEF, 32'h0);
      wr(`LSTR_OFF_CONN_COND, 32'h1);
      wr(`LSTR_OFF_CONFIG, 32'h3C);
      rd(`LSTR_OFF_CONFIG, 32'h3C);
      wr(`LSTR_OFF_CUR_TX, 32'h5);
      rd(`LSTR_OFF_CUR_TX, 32'h5);
      stop_test();
   end
endmodule
